// ===== hdl/pll_pkg.sv
// How it works
// - one serial bit shifted per link clock rise
// - load strobe rise copies word into one latch
// - word bits 1 and 0 pick latch
// - 00 ref, 01 feedback, 10 function, 11 startup
// - 14-bit ref, 6+13-bit feedback dividers
// - feedback latch: gain, main, swallow fields
// - ref latch: precision, test, antibacklash, divider
// - antibacklash width set by two latch bits
// - function and startup latches share layout
// - output select bits 6..4 drive output pin
// - precision 0: lock after three good cycles
// - precision 1: lock after five good cycles
// - lock drops on any error above 25 ns
// - analog lock: open drain, low on errors
// - comparator drives up/down from divider phases
// - enable low powers down, three-states pump
package pll_pkg;
	// word and clock figures
	localparam int WORD_W = 24;
	localparam int CLK_HZ = 25_000_000;
	localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
	// phase error limits in ns
	localparam int LOCK_ERR_NS = 15;
	localparam int UNLOCK_ERR_NS = 25;
	// good cycles needed per precision setting
	localparam logic [2:0] LOCK_CNT_LO = 3'h3;
	localparam logic [2:0] LOCK_CNT_HI = 3'h5;
	// latch select codes
	localparam logic [1:0] SEL_REF = 2'h0;
	localparam logic [1:0] SEL_FB = 2'h1;
	localparam logic [1:0] SEL_FUNC = 2'h2;
	localparam logic [1:0] SEL_INIT = 2'h3;
	// latch values after reset
	localparam logic [23:0] REF_RST = 24'h000004;
	localparam logic [23:0] FB_RST = 24'h000301;
	localparam logic [23:0] FUNC_RST = 24'h000082;
	localparam logic [23:0] INIT_RST = 24'h000083;
	// output select codes
	localparam logic [2:0] MUX_DLOCK = 3'h1;
	localparam logic [2:0] MUX_NDIV = 3'h2;
	localparam logic [2:0] MUX_HIGH = 3'h3;
	localparam logic [2:0] MUX_RDIV = 3'h4;
	localparam logic [2:0] MUX_ALOCK = 3'h5;
	// reference latch fields
	typedef struct packed {
		logic dont_care;
		logic [1:0] zero_bits;
		logic lock_precision_select;
		logic test_mode_hi;
		logic test_mode_lo;
		logic antibacklash_width_bit_hi;
		logic antibacklash_width_bit_lo;
		logic [13:0] ref_div;
		logic latch_select_hi;
		logic latch_select_lo;
	} pll_ref_t;
	// feedback latch fields
	typedef struct packed {
		logic [1:0] dont_care;
		logic pump_gain_select;
		logic [12:0] main_cnt;
		logic [5:0] swallow_cnt;
		logic latch_select_hi;
		logic latch_select_lo;
	} pll_fb_t;
	// function and startup latch fields
	typedef struct packed {
		logic [1:0] presc_sel;
		logic power_down_second;
		logic [2:0] cur_set2;
		logic [2:0] cur_set1;
		logic [3:0] timer_ctl;
		logic fastlock_mode;
		logic fastlock_en;
		logic pump_tristate;
		logic pd_polarity;
		logic output_select_bit2;
		logic output_select_bit1;
		logic output_select_bit0;
		logic power_down_first;
		logic counter_reset_bit;
		logic latch_select_hi;
		logic latch_select_lo;
	} pll_func_t;
	// comparator states, gray along idle-up-both-down
	typedef enum logic [1:0] {
		PFD_IDLE = 2'b00,
		PFD_UP = 2'b01,
		PFD_BOTH = 2'b11,
		PFD_DN = 2'b10
	} pll_pfd_t;
endpackage

// ===== hdl/pll_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for pin inputs
module pll_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r; // first stage, read only by second
	logic [WIDTH-1:0] stage2_r; // settled copy
	// two flops, only the second one reads the first
	always_ff @(posedge clock) begin
		if (!rstn) begin
			meta_r <= '0;
			stage2_r <= '0;
		end else begin
			meta_r <= async_in;
			stage2_r <= meta_r;
		end
	end
	assign sync_out = stage2_r;
endmodule // pll_sync

// ===== hdl/pll_latch_lock.sv
`timescale 1ns/1ps
// serial latch front end, dividers, comparator and lock detect
module pll_latch_lock
	import pll_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic serial_clock,
	input wire logic serial_data,
	input wire logic latch_load_strobe,
	input wire logic chip_enable,
	input wire logic ref_in,
	input wire logic fb_in,
	output logic pump_up,
	output logic pump_dn,
	output logic pump_oe_n,
	output logic modulus_ctl,
	output logic [1:0] presc_sel,
	output logic pump_gain,
	output logic lock_detect,
	output logic power_down,
	output logic selectable_output_pin,
	output logic selectable_output_pin_oe_n
);
	// output pin pick for push-pull codes
	function automatic logic mux_pick(input logic [2:0] code,
		input logic dl, input logic nd, input logic rd);
		logic v;
		v = 1'b0;
		case (code)
			MUX_DLOCK: v = dl;
			MUX_NDIV: v = nd;
			MUX_HIGH: v = 1'b1;
			MUX_RDIV: v = rd;
			default: v = 1'b0;
		endcase
		return v;
	endfunction

	logic [WORD_W-1:0] sr_r; // link-side shift register
	// link domain: no reset, pure data; runs only while host clocks
	always_ff @(posedge serial_clock) begin
		sr_r <= {sr_r[WORD_W-2:0], serial_data};
	end

	property p_shift;
		@(posedge serial_clock) 1'b1 |=> sr_r[0] == $past(serial_data);
	endproperty
	a_shift: assert property (p_shift)
		else $error("shift register missed a serial bit");

	logic [3:0] pin_s; // synchronised pins
	logic ce_s, le_s, ref_s, fb_s;
	pll_sync #(.WIDTH(4)) u_sync (
		.clock(clock),
		.rstn(rstn),
		.async_in({chip_enable, latch_load_strobe, ref_in, fb_in}),
		.sync_out(pin_s)
	);
	assign {ce_s, le_s, ref_s, fb_s} = pin_s;

	logic le_q_r, ref_q_r, fb_q_r; // previous synced levels
	// edge history for strobe and divider inputs
	always_ff @(posedge clock) begin
		if (!rstn) begin
			le_q_r <= 1'b0;
			ref_q_r <= 1'b0;
			fb_q_r <= 1'b0;
		end else begin
			le_q_r <= le_s;
			ref_q_r <= ref_s;
			fb_q_r <= fb_s;
		end
	end
	logic le_rise, ref_edge, fb_edge;
	assign le_rise = le_s & ~le_q_r;
	assign ref_edge = ref_s & ~ref_q_r;
	assign fb_edge = fb_s & ~fb_q_r;

	// the word is still while the strobe rises: the host has stopped
	// the link clock, so the synced strobe qualifies the crossing
	logic [1:0] sel_w; // destination code
	logic [3:0] load_hit; // one-hot latch write
	assign sel_w = sr_r[1:0];
	assign load_hit = le_rise ? (4'h1 << sel_w) : 4'h0;

	logic [WORD_W-1:0] latch_r [4]; // the four config latches
	localparam logic [23:0] LATCH_RST [4] =
		'{REF_RST, FB_RST, FUNC_RST, INIT_RST};
	generate
		for (genvar i = 0; i < 4; i++) begin : g_latch
			// each latch changes only when its code is loaded
			always_ff @(posedge clock) begin
				if (!rstn) begin
					latch_r[i] <= LATCH_RST[i];
				end else if (load_hit[i]) begin
					latch_r[i] <= sr_r;
				end
			end
			property p_hold;
				@(posedge clock) disable iff (!rstn)
				!load_hit[i] |=> $stable(latch_r[i]);
			endproperty
			a_hold: assert property (p_hold)
				else $error("latch changed without its load");
		end
	endgenerate

	property p_load;
		@(posedge clock) disable iff (!rstn)
		le_rise |=> latch_r[$past(sel_w)] == $past(sr_r);
	endproperty
	a_load: assert property (p_load)
		else $error("selected latch did not take the word");

	logic use_init_r; // startup latch written last
	// the later of function or startup load steers the device
	always_ff @(posedge clock) begin
		if (!rstn) begin
			use_init_r <= 1'b0;
		end else if (load_hit[SEL_INIT]) begin
			use_init_r <= 1'b1;
		end else if (load_hit[SEL_FUNC]) begin
			use_init_r <= 1'b0;
		end
	end

	pll_ref_t ref_w; // reference latch view
	pll_fb_t fb_w; // feedback latch view
	pll_func_t func_w; // active function view
	assign ref_w = pll_ref_t'(latch_r[SEL_REF]);
	assign fb_w = pll_fb_t'(latch_r[SEL_FB]);
	assign func_w = use_init_r ? pll_func_t'(latch_r[SEL_INIT])
		: pll_func_t'(latch_r[SEL_FUNC]);

	logic powered, hold_cnt;
	assign powered = ce_s & ~func_w.power_down_first;
	assign hold_cnt = ~powered | func_w.counter_reset_bit
		| load_hit[SEL_INIT];

	logic [13:0] r_cnt_r; // reference divider count
	logic r_pulse_r, r_tog_r; // divider pulse and square
	logic r_wrap;
	assign r_wrap = ({1'b0, r_cnt_r} + 15'h1) >= {1'b0, ref_w.ref_div};
	// reference divider: one pulse every ref_div input edges
	always_ff @(posedge clock) begin
		if (!rstn || hold_cnt) begin
			r_cnt_r <= 14'h0;
			r_pulse_r <= 1'b0;
		end else begin
			r_pulse_r <= ref_edge & r_wrap;
			if (ref_edge) begin
				r_cnt_r <= r_wrap ? 14'h0 : r_cnt_r + 14'h1;
			end
		end
	end

	logic [12:0] b_cnt_r; // main counter
	logic [5:0] a_cnt_r; // swallow counter
	logic n_pulse_r, n_tog_r, mod_r;
	logic n_wrap;
	assign n_wrap = ({1'b0, b_cnt_r} + 14'h1) >= {1'b0, fb_w.main_cnt};
	// feedback divider: swallow phase asks prescaler for p+1
	always_ff @(posedge clock) begin
		if (!rstn || hold_cnt) begin
			b_cnt_r <= 13'h0;
			a_cnt_r <= 6'h0;
			n_pulse_r <= 1'b0;
			mod_r <= 1'b0;
		end else begin
			n_pulse_r <= fb_edge & n_wrap;
			mod_r <= a_cnt_r < fb_w.swallow_cnt;
			if (fb_edge && n_wrap) begin
				b_cnt_r <= 13'h0;
				a_cnt_r <= 6'h0;
			end else if (fb_edge) begin
				b_cnt_r <= b_cnt_r + 13'h1;
				if (a_cnt_r < fb_w.swallow_cnt) begin
					a_cnt_r <= a_cnt_r + 6'h1;
				end
			end
		end
	end

	// divider squares for the output pin
	always_ff @(posedge clock) begin
		if (!rstn) begin
			r_tog_r <= 1'b0;
			n_tog_r <= 1'b0;
		end else begin
			r_tog_r <= r_tog_r ^ r_pulse_r;
			n_tog_r <= n_tog_r ^ n_pulse_r;
		end
	end

	pll_pfd_t st_r, st_nxt; // comparator state
	logic [1:0] ab_cnt_r; // cycles spent with both on
	logic [1:0] abw_w; // antibacklash width code
	logic [7:0] err_cnt_r; // cycles of one-sided drive
	assign abw_w = {ref_w.antibacklash_width_bit_hi,
		ref_w.antibacklash_width_bit_lo};

	// comparator: first arriving edge drives, second ends the pulse
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			PFD_IDLE: begin
				if (r_pulse_r && n_pulse_r) begin
					st_nxt = PFD_BOTH;
				end else if (r_pulse_r) begin
					st_nxt = PFD_UP;
				end else if (n_pulse_r) begin
					st_nxt = PFD_DN;
				end
			end
			PFD_UP: begin
				if (n_pulse_r) begin
					st_nxt = PFD_BOTH;
				end
			end
			PFD_DN: begin
				if (r_pulse_r) begin
					st_nxt = PFD_BOTH;
				end
			end
			PFD_BOTH: begin
				if (ab_cnt_r == abw_w) begin
					st_nxt = PFD_IDLE;
				end
			end
			default: st_nxt = PFD_IDLE;
		endcase
	end

	logic one_side, eval;
	logic [8:0] err_now; // error cycles including this one
	assign one_side = (st_r == PFD_UP) || (st_r == PFD_DN);
	assign err_now = one_side ? {1'b0, err_cnt_r} + 9'h1 : 9'h0;
	assign eval = (st_r != PFD_BOTH) && (st_nxt == PFD_BOTH);

	// state, antibacklash timer, error length
	always_ff @(posedge clock) begin
		if (!rstn || hold_cnt) begin
			st_r <= PFD_IDLE;
			ab_cnt_r <= 2'h0;
			err_cnt_r <= 8'h0;
		end else begin
			st_r <= st_nxt;
			ab_cnt_r <= (st_r == PFD_BOTH) ? ab_cnt_r + 2'h1 : 2'h0;
			if (one_side && err_cnt_r != 8'hff) begin
				err_cnt_r <= err_cnt_r + 8'h1;
			end else if (st_r == PFD_IDLE) begin
				err_cnt_r <= 8'h0;
			end
		end
	end

	logic err_good, err_bad;
	logic [2:0] need_w; // good cycles required
	logic [2:0] good_cnt_r;
	logic dig_lock_r;
	assign err_good = (32'(err_now) * CLK_NS) < LOCK_ERR_NS;
	assign err_bad = (32'(err_now) * CLK_NS) > UNLOCK_ERR_NS;
	assign need_w = ref_w.lock_precision_select ? LOCK_CNT_HI
		: LOCK_CNT_LO;

	// digital lock: count good comparisons, drop on a bad one
	always_ff @(posedge clock) begin
		if (!rstn) begin
			good_cnt_r <= 3'h0;
			dig_lock_r <= 1'b0;
		end else if (eval) begin
			if (err_bad) begin
				good_cnt_r <= 3'h0;
				dig_lock_r <= 1'b0;
			end else if (err_good) begin
				if (good_cnt_r + 3'h1 >= need_w) begin
					dig_lock_r <= 1'b1;
				end
				if (good_cnt_r < need_w) begin
					good_cnt_r <= good_cnt_r + 3'h1;
				end
			end else begin
				good_cnt_r <= 3'h0;
			end
		end
	end

	logic up_w, dn_w, drive_ok;
	logic [2:0] osel_w;
	assign up_w = (st_r == PFD_UP) || (st_r == PFD_BOTH);
	assign dn_w = (st_r == PFD_DN) || (st_r == PFD_BOTH);
	assign drive_ok = powered & ~func_w.pump_tristate;
	assign osel_w = {func_w.output_select_bit2,
		func_w.output_select_bit1, func_w.output_select_bit0};

	logic up_r, dn_r, oe_n_r, mux_r, mux_oe_n_r, pd_r;
	logic [1:0] presc_r;
	logic gain_r;
	// registered pins; polarity swaps the pump sense
	always_ff @(posedge clock) begin
		if (!rstn) begin
			up_r <= 1'b0;
			dn_r <= 1'b0;
			oe_n_r <= 1'b1;
			mux_r <= 1'b0;
			mux_oe_n_r <= 1'b1;
			pd_r <= 1'b1;
			presc_r <= 2'h0;
			gain_r <= 1'b0;
		end else begin
			up_r <= drive_ok & (func_w.pd_polarity ? up_w : dn_w);
			dn_r <= drive_ok & (func_w.pd_polarity ? dn_w : up_w);
			oe_n_r <= ~drive_ok;
			pd_r <= ~powered;
			presc_r <= func_w.presc_sel;
			gain_r <= fb_w.pump_gain_select;
			if (osel_w == MUX_ALOCK) begin
				mux_r <= 1'b0;
				mux_oe_n_r <= ~(up_w ^ dn_w);
			end else begin
				mux_r <= mux_pick(osel_w, dig_lock_r, n_tog_r,
					r_tog_r);
				mux_oe_n_r <= 1'b0;
			end
		end
	end

	assign pump_up = up_r;
	assign pump_dn = dn_r;
	assign pump_oe_n = oe_n_r;
	assign modulus_ctl = mod_r;
	assign presc_sel = presc_r;
	assign pump_gain = gain_r;
	assign lock_detect = dig_lock_r;
	assign power_down = pd_r;
	assign selectable_output_pin = mux_r;
	assign selectable_output_pin_oe_n = mux_oe_n_r;

	property p_lock_lo;
		@(posedge clock) disable iff (!rstn)
		$rose(dig_lock_r) && !ref_w.lock_precision_select
			|-> $past(good_cnt_r) >= LOCK_CNT_LO - 3'h1;
	endproperty
	a_lock_lo: assert property (p_lock_lo)
		else $error("lock set before three good cycles");

	property p_lock_hi;
		@(posedge clock) disable iff (!rstn)
		$rose(dig_lock_r) && ref_w.lock_precision_select
			|-> $past(good_cnt_r) == LOCK_CNT_HI - 3'h1;
	endproperty
	a_lock_hi: assert property (p_lock_hi)
		else $error("lock set before five good cycles");

	property p_unlock;
		@(posedge clock) disable iff (!rstn)
		eval && err_bad |=> !dig_lock_r ##1 !dig_lock_r;
	endproperty
	a_unlock: assert property (p_unlock)
		else $error("lock kept after large phase error");

	property p_lock_stay;
		@(posedge clock) disable iff (!rstn)
		dig_lock_r && !(eval && err_bad) |=> dig_lock_r;
	endproperty
	a_lock_stay: assert property (p_lock_stay)
		else $error("lock dropped without a bad cycle");

	property p_backlash;
		@(posedge clock) disable iff (!rstn)
		st_r == PFD_BOTH && ab_cnt_r != abw_w && !hold_cnt
			|=> st_r == PFD_BOTH;
	endproperty
	a_backlash: assert property (p_backlash)
		else $error("antibacklash pulse ended early");

	property p_pfd_up;
		@(posedge clock) disable iff (!rstn)
		st_r == PFD_IDLE && r_pulse_r && !n_pulse_r && !hold_cnt
			|=> up_w && !dn_w;
	endproperty
	a_pfd_up: assert property (p_pfd_up)
		else $error("reference lead did not drive up");

	property p_tristate;
		@(posedge clock) disable iff (!rstn)
		!powered |=> pump_oe_n && !pump_up && !pump_dn;
	endproperty
	a_tristate: assert property (p_tristate)
		else $error("pump driven while powered down");

	property p_mux_lock;
		@(posedge clock) disable iff (!rstn)
		osel_w == MUX_DLOCK |=> selectable_output_pin
			== $past(dig_lock_r) && !selectable_output_pin_oe_n;
	endproperty
	a_mux_lock: assert property (p_mux_lock)
		else $error("output pin does not show lock");

	property p_alock;
		@(posedge clock) disable iff (!rstn)
		osel_w == MUX_ALOCK && !(up_w ^ dn_w)
			|=> selectable_output_pin_oe_n;
	endproperty
	a_alock: assert property (p_alock)
		else $error("analog lock pulled low without error");
endmodule // pll_latch_lock

// ===== bench/pll_host_model.sv
`timescale 1ns/1ps
// host side of the three-wire link: shifts one word, then pulses the load
module pll_host_model
	import pll_pkg::*;
(
	output logic serial_clock,
	output logic serial_data,
	output logic latch_load_strobe
);
	// link clock half period in ns, 30 ns per bit
	localparam int HALF_NS = 15;
	// strobe high and low times, above four and three system clocks
	localparam int STB_NS = 200;

	// link at rest: clock stands low, strobe low
	initial begin
		serial_clock = 1'b0;
		serial_data = 1'b0;
		latch_load_strobe = 1'b0;
	end

	// shift a word msb first, stop the link clock, then load it
	task automatic send_word(input logic [WORD_W-1:0] word);
		for (int i = WORD_W - 1; i >= 0; i--) begin
			// data changes while the link clock is low
			serial_data = word[i];
			#(HALF_NS);
			serial_clock = 1'b1;
			#(HALF_NS);
			serial_clock = 1'b0;
		end
		// released data line no longer shows the last bit
		serial_data = ~word[0];
		#(STB_NS);
		latch_load_strobe = 1'b1;
		#(STB_NS);
		latch_load_strobe = 1'b0;
		#(STB_NS);
	endtask
endmodule // pll_host_model

// ===== bench/testbench.sv
`timescale 1ns/1ps
// compare one value with its expectation and count the outcome
`define CHK(got, exp) begin \
	cmp_count++; \
	if ((got) !== (exp)) begin \
		num_errors++; \
		$display("BAD %0t: got %0h want %0h", $time, got, exp); \
	end \
end

// top of the bench: host model, design and the test sequence
module testbench;
	import pll_pkg::*;
	// design pins
	logic clock, rstn, chip_enable, ref_in, fb_in;
	logic serial_clock, serial_data, latch_load_strobe;
	logic pump_up, pump_dn, pump_oe_n, pump_gain, lock_detect;
	logic power_down, selectable_output_pin, selectable_output_pin_oe_n;
	logic [1:0] presc_sel;
	logic modulus_ctl;
	// bookkeeping
	int num_errors, cmp_count, cycles, both_cnt, up_cnt;
	// output select codes that must give a plain level
	logic [2:0] mux_codes [4];

	pll_host_model host (
		.serial_clock(serial_clock),
		.serial_data(serial_data),
		.latch_load_strobe(latch_load_strobe)
	);

	pll_latch_lock dut (
		.clock(clock),
		.rstn(rstn),
		.serial_clock(serial_clock),
		.serial_data(serial_data),
		.latch_load_strobe(latch_load_strobe),
		.chip_enable(chip_enable),
		.ref_in(ref_in),
		.fb_in(fb_in),
		.pump_up(pump_up),
		.pump_dn(pump_dn),
		.pump_oe_n(pump_oe_n),
		.modulus_ctl(modulus_ctl),
		.presc_sel(presc_sel),
		.pump_gain(pump_gain),
		.lock_detect(lock_detect),
		.power_down(power_down),
		.selectable_output_pin(selectable_output_pin),
		.selectable_output_pin_oe_n(selectable_output_pin_oe_n)
	);

	// 25 MHz system clock
	always #20 clock = ~clock;

	// pump watcher: clocks with both drives up, and up alone
	// sampled on the falling edge, where the registered pins are settled
	always @(negedge clock) begin
		if (pump_up === 1'b1 && pump_dn === 1'b1) begin
			both_cnt++;
		end
		if (pump_up === 1'b1 && pump_dn === 1'b0) begin
			up_cnt++;
		end
	end

	// hang guard, far above the length of the sequence
	always @(posedge clock) begin
		cycles++;
		if (cycles == 6000) begin
			num_errors++;
			give_verdict();
		end
	end

	// verdict and end of run
	task automatic give_verdict();
		if (num_errors == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// reference latch word
	function automatic logic [23:0] ref_word(input logic prec,
		input logic [1:0] abw, input logic [13:0] div);
		return {3'h0, prec, 2'h0, abw, div, SEL_REF};
	endfunction

	// feedback latch word
	function automatic logic [23:0] fb_word(input logic gain,
		input logic [12:0] main, input logic [5:0] sw);
		return {2'h0, gain, main, sw, SEL_FB};
	endfunction

	// function or startup word, polarity bit set, pump not three-stated
	function automatic logic [23:0] cfg_word(input logic [1:0] sel,
		input logic [1:0] presc, input logic [2:0] mux, input logic pd1);
		return {presc, 1'b0, 10'h000, 3'h0, 1'b1, mux, pd1, 1'b0, sel};
	endfunction

	// send a word and let the loaded value reach the pins
	task automatic load(input logic [23:0] w);
		host.send_word(w);
		@(negedge clock);
	endtask

	// one comparator cycle: three input edges, fb lagging by skew clocks
	task automatic pd_cycle(input int skew);
		both_cnt = 0;
		up_cnt = 0;
		repeat (3) begin
			ref_in = 1'b1;
			repeat (skew) @(negedge clock);
			fb_in = 1'b1;
			repeat (4) @(negedge clock);
			ref_in = 1'b0;
			fb_in = 1'b0;
			repeat (8) @(negedge clock);
		end
	endtask

	// test sequence
	initial begin
		clock = 1'b0;
		rstn = 1'b0;
		chip_enable = 1'b0;
		ref_in = 1'b0;
		fb_in = 1'b0;
		num_errors = 0;
		cmp_count = 0;
		cycles = 0;
		mux_codes = '{3'h0, MUX_HIGH, 3'h6, 3'h7};
		repeat (4) @(negedge clock);
		`CHK(power_down, 1'b1)
		`CHK(pump_oe_n, 1'b1)
		`CHK(lock_detect, 1'b0)
		rstn = 1'b1;
		chip_enable = 1'b1;
		// latch steering and field placement
		load(cfg_word(SEL_FUNC, 2'h2, MUX_HIGH, 1'b0));
		`CHK(presc_sel, 2'h2)
		`CHK(selectable_output_pin, 1'b1)
		`CHK(power_down, 1'b0)
		load(fb_word(1'b1, 13'h0003, 6'h00));
		`CHK(pump_gain, 1'b1)
		`CHK(presc_sel, 2'h2)
		load(ref_word(1'b1, 2'h3, 14'h0003));
		`CHK(pump_gain, 1'b1)
		`CHK(presc_sel, 2'h2)
		// plain-level output select codes
		foreach (mux_codes[i]) begin
			load(cfg_word(SEL_FUNC, 2'h0, mux_codes[i], 1'b0));
			`CHK(selectable_output_pin, mux_codes[i] == MUX_HIGH)
		end
		// software and pin power-down
		load(cfg_word(SEL_FUNC, 2'h0, MUX_HIGH, 1'b1));
		`CHK(power_down, 1'b1)
		load(cfg_word(SEL_FUNC, 2'h0, MUX_HIGH, 1'b0));
		chip_enable = 1'b0;
		repeat (4) @(negedge clock);
		`CHK(power_down, 1'b1)
		`CHK(pump_oe_n, 1'b1)
		chip_enable = 1'b1;
		// startup load restarts both dividers in step
		load(cfg_word(SEL_INIT, 2'h1, MUX_DLOCK, 1'b0));
		`CHK(presc_sel, 2'h1)
		`CHK(pump_oe_n, 1'b0)
		// precision 1: five good cycles needed
		repeat (4) pd_cycle(0);
		`CHK(lock_detect, 1'b0)
		`CHK(both_cnt, 4)
		`CHK(up_cnt, 0)
		pd_cycle(0);
		`CHK(lock_detect, 1'b1)
		`CHK(selectable_output_pin, 1'b1)
		// one late feedback edge breaks lock
		pd_cycle(4);
		`CHK(up_cnt > 0, 1'b1)
		`CHK(lock_detect, 1'b0)
		// precision 0: three good cycles, narrowest antibacklash
		load(ref_word(1'b0, 2'h0, 14'h0003));
		repeat (2) pd_cycle(0);
		`CHK(lock_detect, 1'b0)
		`CHK(both_cnt, 1)
		pd_cycle(0);
		`CHK(lock_detect, 1'b1)
		// analog lock code: pin released while the comparator rests
		load(cfg_word(SEL_FUNC, 2'h0, MUX_ALOCK, 1'b0));
		`CHK(selectable_output_pin, 1'b0)
		`CHK(selectable_output_pin_oe_n, 1'b1)
		// swallow count above zero asks the prescaler for p+1
		load(fb_word(1'b1, 13'h0003, 6'h02));
		`CHK(modulus_ctl, 1'b1)
		give_verdict();
	end
endmodule // testbench
